// [src/dual_uart_irq_and_clock_gate.sv]
// Behaviour
// - ports share one interrupt pin.
// - oscillator off while I/O enable 0.
// - oscillator on with base set, enable 1.
// - serial and modem pins idle high.
// - modem pins are general purpose I/O.
// - start low, data, parity, stops high.
// - parity odd, even, mark or space.
// - rates 1200 to 2.7648M baud.
// - transmit rate error below 0.2 percent.
// - receiver takes 2 percent rate error.
// - loader clock is bus clock over 128.
// - port requests only with gate bit 1.
// - bit rate is reference over 16 times divisor.
`timescale 1ns/1ps
`default_nettype none
module dual_uart_irq_and_clock_gate (
    input wire logic core_clk_in,         // 200 MHz clock
    input wire logic sys_rst_in,          // sync reset, high
    input wire logic psel_in,             // apb select
    input wire logic penable_in,          // apb enable
    input wire logic pwrite_in,           // apb direction
    input wire logic [7:0] paddr_in,      // apb byte address
    input wire logic [31:0] pwdata_in,    // apb write data
    output logic [31:0] prdata_out,       // apb read data
    output logic pready_out,              // apb ready
    output logic pslverr_out,             // apb error
    input wire logic [1:0] rxd_in,        // serial data in
    input wire logic [1:0] cts_n_in,      // clear to send, low
    input wire logic [1:0] dsr_n_in,      // data set ready, low
    input wire logic [1:0] ri_n_in,       // ring indicator, low
    input wire logic [1:0] dcd_n_in,      // carrier detect, low
    output logic [1:0] txd_out,           // serial data out
    output logic [1:0] rts_n_out,         // request to send, low
    output logic [1:0] dtr_n_out,         // terminal ready, low
    output logic pci_int_n_out,           // shared interrupt, low
    output logic irq_out,                 // masked status interrupt
    output logic osc_en_out,              // oscillator run
    input wire logic cfg_load_in,         // config load active
    output logic cfg_scl_out              // config serial clock
);
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic io_en;
        logic [31:0] io_base;
        logic osc_run;
        logic [2:0] ist;
        logic [2:0] imask;
        logic [1:0] irq_prev;
        logic int_n;
        logic irq;
    } top_s;

    top_s t_r;
    top_s t_nxt;

    logic acc;
    logic rd_fire;
    logic wr_fire;
    logic [5:0] off;
    logic [1:0] tick;
    logic [1:0] port_irq;
    logic [7:0] port_rdata [2];

    assign acc = psel_in && penable_in;
    // act only where the master sees ready
    assign rd_fire = acc && t_r.pready && !pwrite_in;
    assign wr_fire = acc && t_r.pready && pwrite_in;
    assign off = paddr_in[5:0];

    function automatic logic par_bit(input logic [7:0] d, input logic [1:0] mode);
        case (mode)
            uart_pair_pkg::PAR_ODD: par_bit = ~^d;
            uart_pair_pkg::PAR_EVEN: par_bit = ^d;
            uart_pair_pkg::PAR_MARK: par_bit = 1'b1;
            default: par_bit = 1'b0;
        endcase
    endfunction : par_bit

    ////////////////////////////////////////////////////////////////////////
    for (genvar i = 0; i < 2; i++) begin : g_port
        uart_pair_pkg::port_s p_r;
        uart_pair_pkg::port_s p_nxt;
        logic [3:0] iir_code;
        logic [3:0] msr_now;
        logic sel;

        assign sel = !paddr_in[7] && (paddr_in[6] == 1'(i));
        assign msr_now = {~dcd_n_in[i], ~ri_n_in[i], ~dsr_n_in[i], ~cts_n_in[i]};

        baud_tick_gen u_baud (
            .core_clk_in(core_clk_in),
            .sys_rst_in(sys_rst_in),
            .run_in(t_r.osc_run),
            .divisor_in(p_r.dl),
            .tick_out(tick[i])
        );

        always_comb begin
            if (p_r.interrupt_enable_reg[uart_pair_pkg::IER_LINE] && (p_r.oe || p_r.pe || p_r.fe || p_r.bi)) begin
                iir_code = uart_pair_pkg::IIR_LINE;
            end else if (p_r.interrupt_enable_reg[uart_pair_pkg::IER_RX] && p_r.dr) begin
                iir_code = uart_pair_pkg::IIR_RX;
            end else if (p_r.interrupt_enable_reg[uart_pair_pkg::IER_THRE] && p_r.thre_pend) begin
                iir_code = uart_pair_pkg::IIR_THRE;
            end else if (p_r.interrupt_enable_reg[uart_pair_pkg::IER_MODEM] && |p_r.msr_delta) begin
                iir_code = uart_pair_pkg::IIR_MODEM;
            end else begin
                iir_code = uart_pair_pkg::IIR_NONE;
            end
        end

        // gate bit lets a cause out
        assign port_irq[i] = !iir_code[0] && p_r.modem_control_reg[uart_pair_pkg::MCR_GATE];

        always_comb begin
            if (off == uart_pair_pkg::OFF_DATA) begin
                port_rdata[i] = p_r.rbr;
            end else if (off == uart_pair_pkg::OFF_IER) begin
                port_rdata[i] = {4'h0, p_r.interrupt_enable_reg};
            end else if (off == uart_pair_pkg::OFF_IIR) begin
                port_rdata[i] = {4'h0, iir_code};
            end else if (off == uart_pair_pkg::OFF_LCR) begin
                port_rdata[i] = p_r.lcr;
            end else if (off == uart_pair_pkg::OFF_MCR) begin
                port_rdata[i] = {3'h0, p_r.modem_control_reg};
            end else if (off == uart_pair_pkg::OFF_LSR) begin
                port_rdata[i] = {1'b0, !p_r.thr_full && !p_r.tx_busy, !p_r.thr_full,
                                 p_r.bi, p_r.fe, p_r.pe, p_r.oe, p_r.dr};
            end else if (off == uart_pair_pkg::OFF_MSR) begin
                port_rdata[i] = {msr_now, p_r.msr_delta};
            end else if (off == uart_pair_pkg::OFF_DLL) begin
                port_rdata[i] = p_r.dl[7:0];
            end else begin
                port_rdata[i] = p_r.dl[15:8];
            end
        end

        always_comb begin
            logic [3:0] nd;
            logic [7:0] mask;
            logic [11:0] frame;
            logic [3:0] flen;
            logic [3:0] rlen;
            logic [11:0] rs;
            logic [7:0] rdat;
            logic rxd;
            nd = 4'h5 + {2'h0, p_r.lcr[1:0]};
            mask = 8'hff >> (4'h8 - nd);
            flen = nd + 4'h2 + {3'h0, p_r.lcr[uart_pair_pkg::LCR_PAREN]} + {3'h0, p_r.lcr[uart_pair_pkg::LCR_STOP]};
            rlen = nd + 4'h2 + {3'h0, p_r.lcr[uart_pair_pkg::LCR_PAREN]};
            frame = 12'hfff;
            frame[0] = 1'b0;
            for (int b = 0; b < 8; b++) begin
                if (b < int'(nd)) begin
                    frame[b + 1] = p_r.thr[b];
                end
            end
            if (p_r.lcr[uart_pair_pkg::LCR_PAREN]) begin
                frame[nd + 4'h1] = par_bit(p_r.thr & mask, p_r.lcr[5:4]);
            end
            rs = p_r.rx_sh;
            rdat = 8'h00;
            rxd = rxd_in[i];
            p_nxt = p_r;

            // read clears first; sets below win
            if (rd_fire && sel) begin
                if (off == uart_pair_pkg::OFF_DATA) begin
                    p_nxt.dr = 1'b0;
                end else if (off == uart_pair_pkg::OFF_IIR && iir_code == uart_pair_pkg::IIR_THRE) begin
                    p_nxt.thre_pend = 1'b0;
                end else if (off == uart_pair_pkg::OFF_LSR) begin
                    p_nxt.oe = 1'b0;
                    p_nxt.pe = 1'b0;
                    p_nxt.fe = 1'b0;
                    p_nxt.bi = 1'b0;
                end else if (off == uart_pair_pkg::OFF_MSR) begin
                    p_nxt.msr_delta = 4'h0;
                end
            end

            // tx: 16 ticks per bit
            if (tick[i]) begin
                if (!p_r.tx_busy && p_r.thr_full) begin
                    p_nxt.tx_busy = 1'b1;
                    p_nxt.tx_sh = frame;
                    p_nxt.tx_sub = 4'h0;
                    p_nxt.tx_cnt = 4'h0;
                    p_nxt.thr_full = 1'b0;
                    p_nxt.thre_pend = 1'b1;
                end else if (p_r.tx_busy) begin
                    p_nxt.tx_sub = p_r.tx_sub + 4'h1;
                    if (p_r.tx_sub == uart_pair_pkg::OVS_LAST) begin
                        p_nxt.tx_cnt = p_r.tx_cnt + 4'h1;
                        p_nxt.tx_sh = {1'b1, p_r.tx_sh[11:1]};
                        if (p_r.tx_cnt == flen - 4'h1) begin
                            p_nxt.tx_busy = 1'b0;
                        end
                    end
                end
            end

            // rx: mid-bit sample eases rate error
            if (tick[i]) begin
                if (!p_r.rx_busy) begin
                    if (!rxd) begin
                        p_nxt.rx_busy = 1'b1;
                        p_nxt.rx_sub = 4'h0;
                        p_nxt.rx_cnt = 4'h0;
                    end
                end else begin
                    p_nxt.rx_sub = p_r.rx_sub + 4'h1;
                    if (p_r.rx_sub == uart_pair_pkg::SAMPLE_POINT) begin
                        rs[p_r.rx_cnt] = rxd;
                        p_nxt.rx_sh = rs;
                        p_nxt.rx_cnt = p_r.rx_cnt + 4'h1;
                        if (p_r.rx_cnt == 4'h0 && rxd) begin
                            p_nxt.rx_busy = 1'b0;
                        end else if (p_r.rx_cnt == rlen - 4'h1) begin
                            p_nxt.rx_busy = 1'b0;
                            rdat = rs[8:1] & mask;
                            p_nxt.rbr = rdat;
                            p_nxt.oe = p_nxt.oe | p_nxt.dr;
                            p_nxt.dr = 1'b1;
                            p_nxt.fe = p_nxt.fe | !rxd;
                            p_nxt.bi = p_nxt.bi | (rs == 12'h000);
                            if (p_r.lcr[uart_pair_pkg::LCR_PAREN]) begin
                                p_nxt.pe = p_nxt.pe | (rs[nd + 4'h1] != par_bit(rdat, p_r.lcr[5:4]));
                            end
                        end
                    end
                end
            end

            // any pin change latches a delta
            p_nxt.msr_prev = msr_now;
            p_nxt.msr_delta = p_nxt.msr_delta | (msr_now ^ p_r.msr_prev);

            if (wr_fire && sel) begin
                if (off == uart_pair_pkg::OFF_DATA) begin
                    p_nxt.thr = pwdata_in[7:0];
                    p_nxt.thr_full = 1'b1;
                    p_nxt.thre_pend = 1'b0;
                end else if (off == uart_pair_pkg::OFF_IER) begin
                    p_nxt.interrupt_enable_reg = pwdata_in[3:0];
                    // enabling the empty source re-arms it
                    if (pwdata_in[uart_pair_pkg::IER_THRE] && !p_r.interrupt_enable_reg[uart_pair_pkg::IER_THRE]
                        && !p_nxt.thr_full) begin
                        p_nxt.thre_pend = 1'b1;
                    end
                end else if (off == uart_pair_pkg::OFF_LCR) begin
                    p_nxt.lcr = pwdata_in[7:0];
                end else if (off == uart_pair_pkg::OFF_MCR) begin
                    p_nxt.modem_control_reg = pwdata_in[4:0];
                end else if (off == uart_pair_pkg::OFF_DLL) begin
                    p_nxt.dl[7:0] = pwdata_in[7:0];
                end else if (off == uart_pair_pkg::OFF_DLM) begin
                    p_nxt.dl[15:8] = pwdata_in[7:0];
                end
            end

            // pins follow control bits
            p_nxt.rts_n = !p_nxt.modem_control_reg[uart_pair_pkg::MCR_RTS];
            p_nxt.dtr_n = !p_nxt.modem_control_reg[uart_pair_pkg::MCR_DTR];
            p_nxt.txd = (p_nxt.tx_busy ? p_nxt.tx_sh[0] : 1'b1) & !p_nxt.lcr[uart_pair_pkg::LCR_BREAK];
        end

        always_ff @(posedge core_clk_in) begin
            if (sys_rst_in) begin
                p_r <= '0;
                p_r.interrupt_enable_reg <= uart_pair_pkg::IER_RST;
                p_r.lcr <= uart_pair_pkg::LCR_RST;
                p_r.modem_control_reg <= uart_pair_pkg::MCR_RST;
                p_r.dl <= uart_pair_pkg::DL_RST;
                p_r.tx_sh <= 12'hfff;
                p_r.msr_prev <= 4'h0;
                p_r.txd <= 1'b1;
                p_r.rts_n <= 1'b1;
                p_r.dtr_n <= 1'b1;
            end else begin
                p_r <= p_nxt;
            end
        end

        assign txd_out[i] = p_r.txd;
        assign rts_n_out[i] = p_r.rts_n;
        assign dtr_n_out[i] = p_r.dtr_n;
    end

    ////////////////////////////////////////////////////////////////////////
    cfg_scl_div u_scl (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .load_in(cfg_load_in),
        .scl_out(cfg_scl_out)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [31:0] rd;
        logic ok;
        rd = 32'h0;
        ok = 1'b0;
        t_nxt = t_r;

        // one wait state
        t_nxt.pready = acc && !t_r.pready;
        if (paddr_in[1:0] != 2'h0) begin
            ok = 1'b0;
        end else if (!paddr_in[7]) begin
            ok = off <= uart_pair_pkg::OFF_DLM;
            rd = {24'h0, port_rdata[paddr_in[6]]};
        end else if (paddr_in == uart_pair_pkg::OFF_CMD) begin
            ok = 1'b1;
            rd = {31'h0, t_r.io_en};
        end else if (paddr_in == uart_pair_pkg::OFF_IOBASE) begin
            ok = 1'b1;
            rd = t_r.io_base;
        end else if (paddr_in == uart_pair_pkg::OFF_IRQ_STAT) begin
            ok = 1'b1;
            rd = {29'h0, t_r.ist};
        end else if (paddr_in == uart_pair_pkg::OFF_IRQ_MASK) begin
            ok = 1'b1;
            rd = {29'h0, t_r.imask};
        end
        t_nxt.prdata = t_nxt.pready && ok ? rd : 32'h0;
        t_nxt.pslverr = t_nxt.pready && !ok;

        if (rd_fire && paddr_in == uart_pair_pkg::OFF_IRQ_STAT) begin
            t_nxt.ist = 3'h0;
        end
        if (wr_fire) begin
            if (paddr_in == uart_pair_pkg::OFF_CMD) begin
                t_nxt.io_en = pwdata_in[uart_pair_pkg::CMD_IO_EN];
            end else if (paddr_in == uart_pair_pkg::OFF_IOBASE) begin
                t_nxt.io_base = pwdata_in;
            end else if (paddr_in == uart_pair_pkg::OFF_IRQ_MASK) begin
                t_nxt.imask = pwdata_in[2:0];
            end
        end

        // needs enable and an assigned base
        t_nxt.osc_run = t_r.io_en && (t_r.io_base != 32'h0);
        // set after read clear: event wins
        t_nxt.ist = t_nxt.ist | {3'(t_nxt.osc_run && !t_r.osc_run) << uart_pair_pkg::IST_OSC}
                    | {1'b0, port_irq & ~t_r.irq_prev};
        t_nxt.irq_prev = port_irq;
        t_nxt.int_n = !(|port_irq);
        t_nxt.irq = |(t_nxt.ist & t_nxt.imask);
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            t_r <= '0;
            t_r.imask <= uart_pair_pkg::IMASK_RST;
            t_r.int_n <= 1'b1;
        end else begin
            t_r <= t_nxt;
        end
    end

    assign prdata_out = t_r.prdata;
    assign pready_out = t_r.pready;
    assign pslverr_out = t_r.pslverr;
    assign pci_int_n_out = t_r.int_n;
    assign irq_out = t_r.irq;
    assign osc_en_out = t_r.osc_run;
endmodule : dual_uart_irq_and_clock_gate
`default_nettype wire

// [src/uart_pair_pkg.sv]
`default_nettype none
package uart_pair_pkg;
    // byte offsets in a port window
    localparam logic [5:0] OFF_DATA = 6'h00;
    localparam logic [5:0] OFF_IER = 6'h04;
    localparam logic [5:0] OFF_IIR = 6'h08;
    localparam logic [5:0] OFF_LCR = 6'h0c;
    localparam logic [5:0] OFF_MCR = 6'h10;
    localparam logic [5:0] OFF_LSR = 6'h14;
    localparam logic [5:0] OFF_MSR = 6'h18;
    localparam logic [5:0] OFF_DLL = 6'h1c;
    localparam logic [5:0] OFF_DLM = 6'h20;
    localparam logic [7:0] PORT_STRIDE = 8'h40;
    // global registers
    localparam logic [7:0] OFF_CMD = 8'h80;
    localparam logic [7:0] OFF_IOBASE = 8'h84;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h88;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h8c;
    // field positions
    localparam int LCR_STOP = 2;
    localparam int LCR_PAREN = 3;
    localparam int LCR_BREAK = 6;
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_GATE = 3;
    localparam int IER_RX = 0;
    localparam int IER_THRE = 1;
    localparam int IER_LINE = 2;
    localparam int IER_MODEM = 3;
    localparam int CMD_IO_EN = 0;
    localparam int IST_OSC = 2;
    // reset values
    localparam logic [3:0] IER_RST = 4'h0;
    localparam logic [7:0] LCR_RST = 8'h00;
    localparam logic [4:0] MCR_RST = 5'h00;
    localparam logic [15:0] DL_RST = 16'h0000;
    localparam logic [2:0] IMASK_RST = 3'h0;
    // identification and parity codes
    localparam logic [3:0] IIR_NONE = 4'h1;
    localparam logic [3:0] IIR_LINE = 4'h6;
    localparam logic [3:0] IIR_RX = 4'h4;
    localparam logic [3:0] IIR_THRE = 4'h2;
    localparam logic [3:0] IIR_MODEM = 4'h0;
    localparam logic [1:0] PAR_ODD = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h1;
    localparam logic [1:0] PAR_MARK = 2'h2;
    // timing
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] SAMPLE_POINT = 4'h7;
    localparam int SCL_DIV = 128;
    localparam logic [6:0] SCL_HALF = 7'(SCL_DIV / 2);

    typedef struct packed {
        logic [3:0] interrupt_enable_reg;
        logic [7:0] lcr;
        logic [4:0] modem_control_reg;
        logic [15:0] dl;
        logic [7:0] thr;
        logic thr_full;
        logic thre_pend;
        logic tx_busy;
        logic [3:0] tx_sub;
        logic [3:0] tx_cnt;
        logic [11:0] tx_sh;
        logic rx_busy;
        logic [3:0] rx_sub;
        logic [3:0] rx_cnt;
        logic [11:0] rx_sh;
        logic [7:0] rbr;
        logic dr;
        logic oe;
        logic pe;
        logic fe;
        logic bi;
        logic [3:0] msr_prev;
        logic [3:0] msr_delta;
        logic txd;
        logic rts_n;
        logic dtr_n;
    } port_s;
endpackage : uart_pair_pkg
`default_nettype wire

// [src/baud_tick_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module baud_tick_gen (
    input wire logic core_clk_in,        // 200 MHz clock
    input wire logic sys_rst_in,         // sync reset, high
    input wire logic run_in,             // oscillator running
    input wire logic [15:0] divisor_in,  // 16-bit divisor
    output logic tick_out                // 16 per bit
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } tick_s;

    tick_s st_r;
    tick_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        // stopped or divisor 0: idle
        if (!run_in || divisor_in == 16'h0) begin
            st_nxt.cnt = 16'h0;
        end else if (st_r.cnt >= divisor_in - 16'h1) begin
            st_nxt.cnt = 16'h0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick_out = st_r.tick;
endmodule : baud_tick_gen
`default_nettype wire

// [src/cfg_scl_div.sv]
`timescale 1ns/1ps
`default_nettype none
module cfg_scl_div (
    input wire logic core_clk_in,  // bus clock
    input wire logic sys_rst_in,   // sync reset, high
    input wire logic load_in,      // config load in progress
    output logic scl_out           // serial clock, idles high
);
    typedef struct packed {
        logic [6:0] cnt;
        logic scl;
    } scl_s;

    scl_s st_r;
    scl_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (!load_in) begin
            st_nxt.cnt = 7'h00;
            st_nxt.scl = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 7'h01;
            st_nxt.scl = (st_nxt.cnt < uart_pair_pkg::SCL_HALF);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            st_r <= {7'h00, 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign scl_out = st_r.scl;
endmodule : cfg_scl_div
`default_nettype wire

// [tb/line_far_end.sv]
`timescale 1ns/1ps
`default_nettype none
module line_far_end (
    input wire logic [1:0] txd_in, // block serial out
    input wire logic [1:0] cts_set_n_in, // bench level
    output logic [1:0] rxd_out, // looped serial in
    output logic [1:0] cts_n_out // handshake in
);
    // loopback
    assign rxd_out = txd_in;
    assign cts_n_out = cts_set_n_in;
endmodule : line_far_end
`default_nettype wire

// [tb/uart_pair_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module uart_pair_sva (
    input wire logic core_clk_in, // clock
    input wire logic sys_rst_in, // reset
    input wire logic psel_in, // apb
    input wire logic penable_in, // apb
    input wire logic pwrite_in, // apb
    input wire logic [31:0] prdata_out, // apb
    input wire logic pready_out, // apb
    input wire logic pslverr_out, // apb
    input wire logic [1:0] txd_out, // serial
    input wire logic [1:0] rts_n_out, // modem
    input wire logic pci_int_n_out, // shared pin
    input wire logic osc_en_out, // oscillator
    input wire logic cfg_load_in, // loader
    input wire logic cfg_scl_out // loader clock
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    ////////////////////////////////////////
    idle_levels_a: assert property ($fell(sys_rst_in) |-> txd_out == 2'h3 && rts_n_out == 2'h3
        && pci_int_n_out && !osc_en_out) else $error("idle levels");
    osc_after_write_a: assert property ($rose(osc_en_out) |-> $past(pready_out && pwrite_in, 2))
        else $error("osc no write");
    modem_after_write_a: assert property ($changed(rts_n_out) |-> $past(pready_out && pwrite_in)
        || $past(pready_out && pwrite_in, 2)) else $error("modem no write");
    scl_half_a: assert property ($fell(cfg_scl_out) && cfg_load_in |-> ##63 (!cfg_scl_out || !cfg_load_in)
        ##1 (cfg_scl_out || !cfg_load_in)) else $error("scl half");
    scl_idle_a: assert property (!cfg_load_in ##1 !cfg_load_in |-> cfg_scl_out)
        else $error("scl idle");
    ready_time_a: assert property (psel_in && !penable_in ##1 psel_in && penable_in |=> pready_out)
        else $error("ready late");
    ready_once_a: assert property (pready_out |=> !pready_out) else $error("ready long");
    data_quiet_a: assert property (!pready_out |-> prdata_out == 32'h0 && !pslverr_out)
        else $error("data leak");
    cover property ($rose(osc_en_out));
    cover property (!pci_int_n_out);
    cover property (pready_out && pslverr_out);
endmodule : uart_pair_sva
bind dual_uart_irq_and_clock_gate uart_pair_sva u_uart_pair_sva (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .txd_out(txd_out),
    .rts_n_out(rts_n_out), .pci_int_n_out(pci_int_n_out), .osc_en_out(osc_en_out),
    .cfg_load_in(cfg_load_in), .cfg_scl_out(cfg_scl_out));
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, load = 1'b0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0, prd, q;
    logic rdy, err, e, pint, irq, osc, scl;
    logic [1:0] rxd, txd, rts_n, dtr_n, cts_n, cts_set = 2'h3;
    int mismatches = 0, check_count = 0, na, nb;
    initial forever #2.5 clk = ~clk;
    dual_uart_irq_and_clock_gate u_dual_uart_irq_and_clock_gate (.core_clk_in(clk), .sys_rst_in(rst),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
        .pready_out(rdy), .pslverr_out(err), .rxd_in(rxd), .cts_n_in(cts_n), .dsr_n_in(2'h3), .ri_n_in(2'h3),
        .dcd_n_in(2'h3), .txd_out(txd), .rts_n_out(rts_n), .dtr_n_out(dtr_n), .pci_int_n_out(pint),
        .irq_out(irq), .osc_en_out(osc), .cfg_load_in(load), .cfg_scl_out(scl));
    line_far_end u_line_far_end (.txd_in(txd), .cts_set_n_in(cts_set), .rxd_out(rxd), .cts_n_out(cts_n));
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] ex, got);
        check_count++;
        if (got !== ex) begin
            $display("BAD %s expected %h seen %h", nm, ex, got);
            mismatches++;
        end
    endtask : chk
    // idle cycle after each transfer
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0);
        int n = 0;
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk) pen <= 1'b1;
        do @(posedge clk) n++; while (rdy !== 1'b1 && n < 50);
        q = prd;
        e = err;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n >= 50) mismatches++;
        @(posedge clk);
    endtask : apb
    task automatic t_reset;
        chk("idle pins", 32'h1fc, {23'h0, txd, rts_n, dtr_n, pint, osc, irq});
        apb(1'b0, {2'h1, uart_pair_pkg::OFF_IIR});
        chk("iir reset", 32'h1, q);
        $display("reset done");
    endtask : t_reset
    task automatic t_osc;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, i == 1 ? uart_pair_pkg::OFF_IOBASE : uart_pair_pkg::OFF_CMD, {31'h0, i != 2});
            repeat (3) @(posedge clk);
            chk("osc enable", {31'h0, i[0]}, {31'h0, osc});
        end
        $display("osc done");
    endtask : t_osc
    task automatic t_gpio;
        apb(1'b1, {2'h1, uart_pair_pkg::OFF_MCR}, 32'h3);
        cts_set <= 2'h2;
        repeat (3) @(posedge clk);
        chk("modem outs", 32'h5, {28'h0, rts_n, dtr_n});
        apb(1'b0, {2'h0, uart_pair_pkg::OFF_MSR});
        chk("modem ins", 32'h11, q & 32'h11);
        cts_set <= 2'h3;
        apb(1'b1, {2'h1, uart_pair_pkg::OFF_MCR});
        $display("gpio done");
    endtask : t_gpio
    task automatic t_serial;
        logic [7:0] lc, d;
        logic [11:0] fr, ex;
        apb(1'b1, {2'h0, uart_pair_pkg::OFF_DLL}, 32'h1);
        for (int i = 0; i < 6; i++) begin
            lc = i < 2 ? {5'h0, i[0], 2'h3} : {2'h0, 2'(i - 2), 4'hb};
            d = 8'h35 + 8'(i * 29);
            ex = {lc[3] ? {2'h3, (lc[5] ? ~lc[4] : ((^d) ^ ~lc[4]))} : 3'h7, d, 1'b0};
            apb(1'b1, {2'h0, uart_pair_pkg::OFF_LCR}, {24'h0, lc});
            apb(1'b1, {2'h0, uart_pair_pkg::OFF_DATA}, {24'h0, d});
            na = 0;
            do @(posedge clk) na++; while (txd[0] !== 1'b0 && na < 100);
            repeat (8) @(posedge clk);
            for (int k = 0; k < 12; k++) begin
                fr[k] = txd[0];
                repeat (16) @(posedge clk);
            end
            chk("tx frame", {20'h0, ex}, {20'h0, fr});
            nb = 0;
            do begin
                apb(1'b0, {2'h0, uart_pair_pkg::OFF_LSR});
                nb++;
            end while (q[0] !== 1'b1 && nb < 20);
            chk("rx status", 32'h1, q & 32'h1f);
            apb(1'b0, {2'h0, uart_pair_pkg::OFF_DATA});
            chk("rx data", {24'h0, d}, q);
        end
        $display("serial done");
    endtask : t_serial
    task automatic t_irq;
        apb(1'b1, uart_pair_pkg::OFF_IRQ_MASK, 32'h1);
        apb(1'b1, {2'h0, uart_pair_pkg::OFF_IER}, 32'h2);
        repeat (3) @(posedge clk);
        chk("gate off", 32'h1, {31'h0, pint});
        apb(1'b1, {2'h0, uart_pair_pkg::OFF_MCR}, 32'h8);
        repeat (3) @(posedge clk);
        chk("gate on", 32'h1, {30'h0, pint, irq});
        apb(1'b0, {2'h0, uart_pair_pkg::OFF_IIR});
        chk("port0 cause", 32'h2, q);
        apb(1'b0, {2'h1, uart_pair_pkg::OFF_IIR});
        chk("port1 cause", 32'h1, q);
        chk("pin released", 32'h1, {31'h0, pint});
        apb(1'b0, uart_pair_pkg::OFF_IRQ_STAT);
        chk("irq status", 32'h1, q & 32'h1);
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b0, 8'h24);
        chk("unmapped", 32'h1, {q[30:0], e});
        $display("irq done");
    endtask : t_irq
    task automatic wl(input logic v, output int n);
        n = 0;
        do @(posedge clk) n++; while (scl !== v && n < 300);
    endtask : wl
    task automatic t_scl;
        load <= 1'b1;
        wl(1'b0, na);
        wl(1'b1, na);
        wl(1'b0, nb);
        chk("scl period", 32'h80, 32'(na + nb));
        load <= 1'b0;
        repeat (3) @(posedge clk);
        chk("scl idle", 32'h1, {31'h0, scl});
        $display("scl done");
    endtask : t_scl
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_osc;
        t_gpio;
        t_serial;
        t_irq;
        t_scl;
        end_sim;
    end
    initial begin
        #60000;
        mismatches++;
        end_sim;
    end
endmodule : tb_top
`default_nettype wire
